//--- src/body_warn_timer.sv
// Purpose: chime, warning lamps and protective unlock pulses of a body
//   controller, with an AXI4-Lite register window
// Assumes: switch pins asynchronous; speed_over is a 10 km/h threshold flag
// Notes: one clock, synchronous active-low reset, ce freezes all state
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module body_warn_timer
  import body_warn_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DEF
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // switch pins
  input wire sw_t sw_pin,
  // lamp, chime and actuator drives
  output lamps_t drive,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  function automatic logic [7:0] count_down(input logic [7:0] c,
                                            input logic t);
    count_down = (t && c != 8'h00) ? c - 8'h01 : c;
  endfunction

  sw_t sync1, sync2, sw_last, db, db_prev;
  logic [24:0] tick_cnt, deb_cnt;
  logic tick;
  logic [1:0] ctrl;
  logic key, ign, drv_open, any_open, lock_edge;
  logic lamp_alert, kr_chime, belt_chime;
  logic [7:0] chime_cnt, blink_cnt, unlk_cnt, win_cnt, belt_cnt;
  logic chime_phase, blink_phase;
  unlk_state_t unlk_state;
  lamps_t next_drive;

  // time base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 25'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (tick_cnt == 25'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 25'(TICK_CYCLES - 1)) ? 25'h0
                  : tick_cnt + 25'h1;
    end
  end

  // pins pass two flops, then a shared stability counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sw_last <= '0;
      deb_cnt <= 25'h0;
      db <= '0;
      db_prev <= '0;
    end else if (ce) begin
      sync1 <= sw_pin;
      sync2 <= sync1;
      sw_last <= sync2;
      db_prev <= db;
      if (sync2 != sw_last) begin
        deb_cnt <= 25'h0;
      end else if (deb_cnt == 25'(DEBOUNCE_CYCLES - 1)) begin
        db <= sw_last;
      end else begin
        deb_cnt <= deb_cnt + 25'h1;
      end
    end
  end

  assign key = db.key_in;
  assign ign = db.ignition_run_input;
  assign drv_open = db.door_open[0];
  assign any_open = |db.door_open;
  assign lock_edge = (db.lock_drv & ~db_prev.lock_drv)
                     | (db.lock_pas & ~db_prev.lock_pas)
                     | (db.lock_cmd & ~db_prev.lock_cmd);

  // key reminder has priority, both stay quiet with ignition run
  assign kr_chime = key & drv_open & ~ign;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamp_alert <= 1'b0;
    end else if (ce) begin
      if (ign) begin
        lamp_alert <= 1'b0;
      end else if (db.tail_lamp & ~key & drv_open) begin
        lamp_alert <= 1'b1;
      end else if (~db.tail_lamp & ~drv_open) begin
        lamp_alert <= 1'b0;
      end
    end
  end

  // shared phase generators for chime pulsing and lamp blinking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chime_cnt <= CHIME_HALF_TICKS;
      chime_phase <= 1'b1;
      blink_cnt <= BLINK_HALF_TICKS;
      blink_phase <= 1'b1;
    end else if (ce && tick) begin
      chime_cnt <= (chime_cnt == 8'h01) ? CHIME_HALF_TICKS
                   : chime_cnt - 8'h01;
      if (chime_cnt == 8'h01) begin
        chime_phase <= ~chime_phase;
      end
      blink_cnt <= (blink_cnt == 8'h01) ? BLINK_HALF_TICKS
                   : blink_cnt - 8'h01;
      if (blink_cnt == 8'h01) begin
        blink_phase <= ~blink_phase;
      end
    end
  end

  // unlock pulse: reminder pulses run out, lockout pulses end on close
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlk_state <= UNLK_IDLE;
      unlk_cnt <= 8'h00;
      win_cnt <= 8'h00;
    end else if (ce) begin
      win_cnt <= count_down(win_cnt, tick);
      if (!key) begin
        win_cnt <= 8'h00;
      end else if (lock_edge) begin
        win_cnt <= CLOSE_WIN_TICKS;
      end
      case (unlk_state)
        UNLK_IDLE: begin
          if (key && drv_open && lock_edge) begin
            unlk_state <= UNLK_REMIND;
            unlk_cnt <= UNLOCK_TICKS;
          // close may debounce in the same cycle as the lock edge
          end else if (key && (win_cnt != 8'h00 || lock_edge) && !drv_open
                       && db_prev.door_open[0]) begin
            unlk_state <= UNLK_REMIND;
            unlk_cnt <= UNLOCK_TICKS;
          end else if (db.tail_lamp && drv_open && !ign && lock_edge) begin
            unlk_state <= UNLK_REMIND;
            unlk_cnt <= UNLOCK_TICKS;
          end else if (!key && any_open && lock_edge && !db.speed_over
                       && ctrl[CTRL_LOCKOUT_BIT]) begin
            unlk_state <= UNLK_LOCKOUT;
            unlk_cnt <= UNLOCK_TICKS;
          end
        end
        UNLK_REMIND: begin
          unlk_cnt <= count_down(unlk_cnt, tick);
          if (unlk_cnt == 8'h00) begin
            unlk_state <= UNLK_IDLE;
          end
        end
        UNLK_LOCKOUT: begin
          // key insertion is deliberately ignored here
          unlk_cnt <= count_down(unlk_cnt, tick);
          if (!any_open || unlk_cnt == 8'h00) begin
            unlk_state <= UNLK_IDLE;
            unlk_cnt <= 8'h00;
          end
        end
        default: begin
          unlk_state <= UNLK_IDLE;
          unlk_cnt <= 8'h00;
        end
      endcase
    end
  end

  // seat belt warning
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      belt_cnt <= 8'h00;
      belt_chime <= 1'b0;
    end else if (ce) begin
      if (!ign) begin
        belt_cnt <= 8'h00;
        belt_chime <= 1'b0;
      end else if (!db_prev.ignition_run_input) begin
        belt_cnt <= BELT_TICKS;
        belt_chime <= ~db.belt_fastened;
      end else if (!db.belt_fastened && db_prev.belt_fastened) begin
        belt_cnt <= BELT_TICKS;
        belt_chime <= 1'b1;
      end else begin
        belt_cnt <= count_down(belt_cnt, tick);
        if (db.belt_fastened || belt_cnt == 8'h00) begin
          belt_chime <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_drive.chime = 1'b0;
    if (kr_chime) begin
      next_drive.chime = 1'b1;
    end else if (lamp_alert) begin
      next_drive.chime = chime_phase;
    end else if (belt_chime && belt_cnt != 8'h00) begin
      next_drive.chime = 1'b1;
    end
    if (!ctrl[CTRL_CHIME_BIT]) begin
      next_drive.chime = 1'b0;
    end
    next_drive.door_ajar_lamp = any_open & (~db.speed_over | blink_phase);
    next_drive.belt_lamp = ign & (belt_cnt != 8'h00) & blink_phase;
    next_drive.unlock = (unlk_cnt != 8'h00);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive <= '0;
    end else if (ce) begin
      drive <= next_drive;
    end
  end

  // axi4-lite write channel
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_awready = ~aw_held & ~s_bvalid;
  assign s_wready = ~w_held & ~s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (aw_held && w_held && !s_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid <= 1'b1;
        if (aw_addr == CTRL_ADDR) begin
          s_bresp <= RESP_OKAY;
          if (w_strb[0]) begin
            ctrl <= w_data[1:0];
          end
        end else if (aw_addr == STATUS_ADDR || aw_addr == INPUTS_ADDR) begin
          s_bresp <= RESP_OKAY;
        end else begin
          s_bresp <= RESP_SLVERR;
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  assign s_arready = ~s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= RESP_OKAY;
        if (s_araddr == CTRL_ADDR) begin
          s_rdata <= {30'h0, ctrl};
        end else if (s_araddr == STATUS_ADDR) begin
          s_rdata <= {22'h0, unlk_state, lamp_alert, belt_chime,
                      kr_chime, drive};
        end else if (s_araddr == INPUTS_ADDR) begin
          s_rdata <= {20'h0, db};
        end else begin
          s_rdata <= 32'h0;
          s_rresp <= RESP_SLVERR;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  property p_key_chime;
    @(posedge aclk) disable iff (!aresetn)
    ce && kr_chime && ctrl[CTRL_CHIME_BIT] |=> drive.chime;
  endproperty
  a_key_chime: assert property (p_key_chime)
    else $error("key reminder chime not sounding");

  property p_chime_quiet;
    @(posedge aclk) disable iff (!aresetn)
    ce && !kr_chime && !lamp_alert && belt_cnt == 8'h00 |=> !drive.chime;
  endproperty
  a_chime_quiet: assert property (p_chime_quiet)
    else $error("chime sounds without a cause");

  property p_ign_inhibit;
    @(posedge aclk) disable iff (!aresetn)
    ce && ign |=> !lamp_alert;
  endproperty
  a_ign_inhibit: assert property (p_ign_inhibit)
    else $error("lamp alert active with ignition run");

  property p_priority;
    @(posedge aclk) disable iff (!aresetn)
    ce && kr_chime && lamp_alert && !chime_phase
      && ctrl[CTRL_CHIME_BIT] |=> drive.chime;
  endproperty
  a_priority: assert property (p_priority)
    else $error("lamp alert pulsing overrides key chime");

  property p_unlock_len;
    @(posedge aclk) disable iff (!aresetn)
    ce && unlk_state == UNLK_IDLE && key && drv_open && lock_edge
      |=> unlk_cnt == UNLOCK_TICKS && unlk_state == UNLK_REMIND;
  endproperty
  a_unlock_len: assert property (p_unlock_len)
    else $error("reminder unlock not loaded with full period");

  property p_lockout_close;
    @(posedge aclk) disable iff (!aresetn)
    ce && unlk_state == UNLK_LOCKOUT && !any_open
      |=> unlk_cnt == 8'h00 ##1 !drive.unlock;
  endproperty
  a_lockout_close: assert property (p_lockout_close)
    else $error("lockout unlock continues after door closed");

  property p_ajar_steady;
    @(posedge aclk) disable iff (!aresetn)
    ce && any_open && !db.speed_over |=> drive.door_ajar_lamp;
  endproperty
  a_ajar_steady: assert property (p_ajar_steady)
    else $error("door ajar lamp not steady at low speed");

  property p_ajar_off;
    @(posedge aclk) disable iff (!aresetn)
    ce && !any_open |=> !drive.door_ajar_lamp;
  endproperty
  a_ajar_off: assert property (p_ajar_off)
    else $error("door ajar lamp lit with doors closed");

  property p_belt_start;
    @(posedge aclk) disable iff (!aresetn)
    ce && ign && !db_prev.ignition_run_input && !db.belt_fastened
      |=> belt_cnt == BELT_TICKS && belt_chime;
  endproperty
  a_belt_start: assert property (p_belt_start)
    else $error("belt warning not started at ignition on");

  property p_belt_off;
    @(posedge aclk) disable iff (!aresetn)
    ce && !ign |=> !drive.belt_lamp && belt_cnt == 8'h00;
  endproperty
  a_belt_off: assert property (p_belt_off)
    else $error("belt warning survives ignition off");

  property p_speed_block;
    @(posedge aclk) disable iff (!aresetn)
    ce && unlk_state == UNLK_IDLE && db.speed_over
      |=> unlk_state != UNLK_LOCKOUT;
  endproperty
  a_speed_block: assert property (p_speed_block)
    else $error("lockout prevention started above threshold");

endmodule

//--- src/body_warn_pkg.sv
// Purpose: constants and types shared by the body warning and lock timer
// Assumes: 200 MHz system clock, 0.1 s time base
// Notes: all second-scale timers count time-base ticks
package body_warn_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_NS = 10_000_000;
  localparam int unsigned DEBOUNCE_CYCLES_DEF = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS = 100;

  // second-scale durations in ms, and as ticks
  localparam int unsigned UNLOCK_MS = 5000;
  localparam int unsigned CLOSE_WIN_MS = 500;
  localparam int unsigned CHIME_PERIOD_MS = 800;
  localparam int unsigned BELT_MS = 6000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam logic [7:0] UNLOCK_TICKS = 8'(UNLOCK_MS / TICK_MS);
  localparam logic [7:0] CLOSE_WIN_TICKS = 8'(CLOSE_WIN_MS / TICK_MS);
  localparam logic [7:0] CHIME_HALF_TICKS = 8'(CHIME_PERIOD_MS / TICK_MS / 2);
  localparam logic [7:0] BELT_TICKS = 8'(BELT_MS / TICK_MS);
  localparam logic [7:0] BLINK_HALF_TICKS = 8'(BLINK_HALF_MS / TICK_MS);

  // register map, byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] INPUTS_ADDR = 8'h08;
  localparam int unsigned CTRL_LOCKOUT_BIT = 0;
  localparam int unsigned CTRL_CHIME_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // switch inputs; lock bits high = LOCK, door bit 0 = driver door
  typedef struct packed {
    logic key_in;
    logic ignition_run_input;
    logic tail_lamp;
    logic belt_fastened;
    logic speed_over;
    logic lock_drv;
    logic lock_pas;
    logic lock_cmd;
    logic [3:0] door_open;
  } sw_t;

  typedef struct packed {
    logic chime;
    logic door_ajar_lamp;
    logic belt_lamp;
    logic unlock;
  } lamps_t;

  typedef enum logic [2:0] {
    UNLK_IDLE = 3'h1,
    UNLK_REMIND = 3'h2,
    UNLK_LOCKOUT = 3'h4
  } unlk_state_t;

endpackage

//--- bench/vehicle_model.sv
// Purpose: switch side of the body controller, seen from its pins
// Assumes: bench commands switch levels; drives observed by the bench
// Notes: no contact bounce modelled, so the debouncer only adds delay
`timescale 1ns/1ps
module vehicle_model
  import body_warn_pkg::*;
(
  // clock
  input wire logic aclk,
  // commanded switches and lamp drives
  input wire sw_t cmd,
  input wire lamps_t drive,
  // switch pins toward the block
  output sw_t sw_pin
);
  // switches change one cycle after the command, like a real contact
  always @(posedge aclk) begin
    sw_pin <= cmd;
  end
endmodule

//--- bench/body_warning_lock_timer_tb.sv
// Purpose: self-checking bench for the warning and lock timer
// Assumes: short tick (10 cycles) and debounce (3 cycles) parameters
// Notes: timing checked with up to two ticks of slack for tick phase
`timescale 1ns/1ps
module body_warning_lock_timer_tb;
  import body_warn_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  sw_t cmd = '0;
  sw_t sw_pin;
  lamps_t drive;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int cmp_count = 0;

  body_warn_timer #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(3)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .sw_pin(sw_pin),
    .drive(drive), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  vehicle_model model_u (.aclk(aclk), .cmd(cmd), .drive(drive),
    .sw_pin(sw_pin));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rng(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    // each channel released only at the edge that takes it
    // no cycle limit here: only the watchdog ends a hung wait
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata; r = rresp;
    rready <= 0;
  endtask

  task automatic set_sw(input sw_t v, input int settle);
    @(posedge aclk);
    cmd <= v;
    repeat (settle) @(posedge aclk);
  endtask

  // high cycles and rising edges of every drive bit over n cycles
  task automatic watch(input int n, output int hi[4], output int ed[4]);
    lamps_t prev;
    prev = drive;
    hi = '{0, 0, 0, 0};
    ed = '{0, 0, 0, 0};
    repeat (n) begin
      @(posedge aclk);
      #1;
      for (int b = 0; b < 4; b++) begin
        if (drive[b]) hi[b]++;
        if (drive[b] && !prev[b]) ed[b]++;
      end
      prev = drive;
    end
  endtask

  initial begin
    #300000;
    mismatches++;
    end_sim();
  end

  initial begin
    sw_t v;
    logic [31:0] d;
    logic [1:0] r;
    int hi[4], ed[4];
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    #1;
    chk(32'(drive), 0);
    axi_rd(CTRL_ADDR, d, r);
    chk(d, 32'(CTRL_RESET));
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(8'h0c, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 0);
    axi_wr(CTRL_ADDR, 32'h1, r);
    axi_rd(CTRL_ADDR, d, r);
    chk(d, 32'h1);
    axi_wr(STATUS_ADDR, 32'hffff, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_wr(CTRL_ADDR, 32'h3, r);
    $display("test registers done");

    v = '0; v.belt_fastened = 1; v.key_in = 1; v.door_open = 4'h1;
    set_sw(v, 20); watch(100, hi, ed);
    chk(hi[3], 100);
    v.ignition_run_input = 1; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[3], 0);
    v.ignition_run_input = 0; v.door_open = 0; set_sw(v, 20);
    watch(100, hi, ed);
    chk(hi[3], 0);
    v.door_open = 4'h1; set_sw(v, 20);
    v.lock_drv = 1; set_sw(v, 0); watch(700, hi, ed);
    chk(rng(hi[0], 480, 515), 1);
    chk(ed[0], 1);
    v.lock_drv = 0; set_sw(v, 20);
    v.lock_drv = 1; v.door_open = 0; set_sw(v, 0); watch(700, hi, ed);
    chk(rng(hi[0], 480, 515), 1);
    v.lock_drv = 0; set_sw(v, 20);
    v.lock_drv = 1; set_sw(v, 10);
    v.key_in = 0; v.door_open = 4'h1; set_sw(v, 10);
    v.door_open = 0; set_sw(v, 0); watch(200, hi, ed);
    chk(hi[0], 0);
    $display("test key reminder done");

    v = '0; v.belt_fastened = 1; v.door_open = 4'h2; set_sw(v, 20);
    v.lock_cmd = 1; set_sw(v, 100);
    v.key_in = 1; set_sw(v, 0); watch(600, hi, ed);
    chk(rng(hi[0], 380, 420), 1);
    v.key_in = 0; v.lock_cmd = 0; set_sw(v, 20);
    v.lock_cmd = 1; set_sw(v, 100);
    v.door_open = 0; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[0], 0);
    chk(hi[2], 0);
    v.lock_cmd = 0; v.door_open = 4'h2; v.speed_over = 1; set_sw(v, 20);
    v.lock_cmd = 1; set_sw(v, 0); watch(400, hi, ed);
    chk(hi[0], 0);
    chk(rng(ed[2], 3, 5), 1);
    v.speed_over = 0; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[2], 100);
    $display("test lockout and ajar done");

    v = '0; v.belt_fastened = 1; v.tail_lamp = 1; v.door_open = 4'h1;
    set_sw(v, 20); watch(400, hi, ed);
    chk(rng(ed[3], 4, 6), 1);
    chk(rng(hi[3], 180, 220), 1);
    v.key_in = 1; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[3], 100);
    // speed flag blocks the lockout path, so only the tail path can fire
    v.key_in = 0; v.lock_drv = 1; v.speed_over = 1;
    set_sw(v, 0); watch(700, hi, ed);
    chk(rng(hi[0], 480, 515), 1);
    v = '0; v.belt_fastened = 1; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[3], 0);
    $display("test lamp alert done");

    v = '0; set_sw(v, 20);
    v.ignition_run_input = 1; set_sw(v, 0); watch(700, hi, ed);
    chk(rng(hi[3], 580, 615), 1);
    chk(rng(ed[1], 5, 7), 1);
    v.ignition_run_input = 0; v.belt_fastened = 1; set_sw(v, 20);
    v.ignition_run_input = 1; set_sw(v, 0); watch(300, hi, ed);
    chk(hi[3], 0);
    chk(32'(ed[1] > 1), 1);
    v.ignition_run_input = 0; v.belt_fastened = 0; set_sw(v, 20);
    v.ignition_run_input = 1; set_sw(v, 100);
    v.ignition_run_input = 0; set_sw(v, 20); watch(100, hi, ed);
    chk(hi[3] + hi[1], 0);
    v.ignition_run_input = 1; set_sw(v, 100);
    v.belt_fastened = 1; set_sw(v, 20); watch(200, hi, ed);
    chk(hi[3], 0);
    chk(32'(ed[1] > 0), 1);
    v.belt_fastened = 0; set_sw(v, 0); watch(700, hi, ed);
    chk(rng(hi[3], 580, 615), 1);
    axi_rd(INPUTS_ADDR, d, r);
    chk(d, 32'(v));
    $display("test belt done");
    end_sim();
  end
endmodule
